//--- hw/i2cm_pkg.sv
// constants for the i2c master receive/stop/arbitration engine
// assumes one 200 MHz clock and a byte-wide register port
package i2cm_pkg;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int BRG_W = 7;
   // ==========================================
   // register offsets
   localparam logic [ADDR_W-1:0] OFF_CON1 = 3'h0;
   localparam logic [ADDR_W-1:0] OFF_CON2 = 3'h1;
   localparam logic [ADDR_W-1:0] OFF_STAT = 3'h2;
   localparam logic [ADDR_W-1:0] OFF_BUF = 3'h3;
   localparam logic [ADDR_W-1:0] OFF_ADD = 3'h4;
   // ==========================================
   // control register one fields
   localparam int B_WRITE_COLLISION = 7;
   localparam int B_OV = 6;
   localparam int B_EN = 5;
   localparam int B_IE = 4;
   localparam int B_BCL = 1;
   localparam int B_FLAG = 0;
   // ==========================================
   // control register two fields
   localparam int B_ACKSTAT = 6;
   localparam int B_ACK_DATA = 5;
   localparam int B_ACK_SEQUENCE_ENABLE = 4;
   localparam int B_RECEIVE_ENABLE = 3;
   localparam int B_PEN = 2;
   localparam int B_RSEN = 1;
   localparam int B_SEN = 0;
   // ==========================================
   // status register fields
   localparam int B_STOPD = 4;
   localparam int B_STARTD = 3;
   localparam int B_BF = 0;
   // ==========================================
   // reset values and counts
   localparam logic [BRG_W-1:0] RST_RELOAD = 7'h00;
   localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
   localparam logic [3:0] CNT_LAST = 4'h7;
   localparam logic [3:0] CNT_ACK = 4'h8;
   localparam logic [1:0] PH0 = 2'h0;
   localparam logic [1:0] PH1 = 2'h1;
   localparam logic [1:0] PH2 = 2'h2;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_TX = 3'b010,
      ST_RX = 3'b011,
      ST_ACK = 3'b100,
      ST_STOP = 3'b101
   } i2cm_state_e;
endpackage

//--- hw/i2cm_brg.sv
// baud generator: down counter that rolls over at zero
// assumes load is driven from state only, never from tick
`timescale 1ns/1ps
module i2cm_brg (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [i2cm_pkg::BRG_W-1:0] reload_i,
   input wire logic load_i,
   output logic tick_o
);
   import i2cm_pkg::*;
   logic [BRG_W-1:0] cnt_q;
   logic [BRG_W-1:0] cnt_d;
   assign tick_o = !load_i && (cnt_q == '0);
   assign cnt_d = (load_i || tick_o) ? reload_i : cnt_q - 7'h01;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_q <= RST_RELOAD;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule // i2cm_brg

//--- hw/i2cm_core.sv
// i2c master engine: receive, acknowledge, stop, start, arbitration
// assumes open-drain pads outside and a one-cycle read port
//
// How it works
// - receive starts on enable bit, idle only
// - each rollover toggles clock; each fall shifts data
// - eighth fall: load buffer, flag, hold clock
// - byte moved sets full; buffer read clears
// - byte while full sets overflow
// - buffer write while busy sets collision
// - ack enable pulls clock, drives ack data
// - ack releases clock, one period, then idle
// - stop drives data low, clock, then data
// - stop seen; one period later done, flag
// - complete byte wakes if interrupt enabled
// - reset or disable clears start, stop bits
// - stop on busy bus raises flag
// - released one sampled zero is collision
// - transmit collision clears full, releases lines
// - condition collision aborts, clears enable bits
// - after collision stop still raises flag
// - new write restarts from first bit
// - line low at start is collision
// - start count; clock low is collision
// - early data low; second count ends start
// - released clock pauses generator until high, except in start
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module i2cm_core (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [i2cm_pkg::ADDR_W-1:0] addr_i,
   input wire logic [i2cm_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [i2cm_pkg::DATA_W-1:0] rdata_o,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   output logic wake_o
);
   import i2cm_pkg::*;

   function automatic logic upd(input logic q, input logic clr, input logic set);
      upd = (q & ~clr) | set;
   endfunction

   // ==========================================
   // state
   i2cm_state_e st_q, st_d;
   logic [1:0] ph_q, ph_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] sr_q, sr_d, buf_q, rdata_q;
   logic [6:0] add_q;
   logic scl_rel_q, scl_rel_d, sda_rel_q, sda_rel_d;
   logic scl_m_q, scl_s_q, scl_p_q;
   logic sda_m_q, sda_s_q, sda_p_q;
   logic en_q, ie_q, write_collision_q, ov_q, bcl_q, flag_q, bf_q;
   logic ack_data_q, ackstat_q, stopd_q, startd_q, wake_q, pin_q;
   logic rx_done, bcl_ev, fin, tx_bf_clr, tx_ack, brg_tick;

   // ==========================================
   // decode
   wire idle = (st_q == ST_IDLE);
   wire wr_con1 = wr_i && (addr_i == OFF_CON1);
   wire wr_con2 = wr_i && (addr_i == OFF_CON2);
   wire wr_buf = wr_i && (addr_i == OFF_BUF);
   wire wr_add = wr_i && (addr_i == OFF_ADD);
   wire rd_buf = rd_i && (addr_i == OFF_BUF);
   wire start_ok = idle && en_q && wr_con2;
   wire go_sen = start_ok && wdata_i[B_SEN];
   wire go_pen = start_ok && wdata_i[B_PEN];
   wire go_ack = start_ok && wdata_i[B_ACK_SEQUENCE_ENABLE];
   wire go_receive_enable = start_ok && wdata_i[B_RECEIVE_ENABLE];
   wire go_tx = idle && en_q && wr_buf;
   wire write_collision_ev = wr_buf && !idle;
   wire ack_data_nx = wr_con2 ? wdata_i[B_ACK_DATA] : ack_data_q;
   wire scl_hi = scl_s_q && scl_p_q;
   wire stop_det = scl_hi && sda_s_q && !sda_p_q;
   wire start_det = scl_hi && !sda_s_q && sda_p_q;
   wire lost_one = sda_rel_q && scl_s_q && !sda_s_q;

   // generator held while idle, while clock is stretched outside start, and while waiting
   wire brg_load = idle
      || (scl_rel_q && !scl_s_q && st_q != ST_START)
      || (st_q == ST_START && ph_q == PH0 && !sda_s_q)
      || (st_q == ST_STOP && ph_q == PH0 && sda_s_q)
      || (st_q == ST_STOP && ph_q == PH2 && !(sda_s_q && scl_s_q));

   i2cm_brg i_i2cm_brg (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .reload_i(add_q),
      .load_i(brg_load),
      .tick_o(brg_tick)
   );

   // ==========================================
   // sequencer
   always_comb begin
      st_d = st_q;
      ph_d = ph_q;
      cnt_d = cnt_q;
      sr_d = sr_q;
      scl_rel_d = scl_rel_q;
      sda_rel_d = sda_rel_q;
      rx_done = 1'b0;
      bcl_ev = 1'b0;
      fin = 1'b0;
      tx_bf_clr = 1'b0;
      tx_ack = 1'b0;
      case (st_q)
         ST_IDLE: begin
            ph_d = PH0;
            cnt_d = 4'h0;
            if (go_sen) begin
               if (!sda_s_q || !scl_s_q) begin
                  bcl_ev = 1'b1;
               end else begin
                  st_d = ST_START;
                  scl_rel_d = 1'b1;
                  sda_rel_d = 1'b1;
               end
            end else if (go_pen) begin
               st_d = ST_STOP;
               sda_rel_d = 1'b0;
            end else if (go_ack) begin
               st_d = ST_ACK;
               scl_rel_d = 1'b0;
               sda_rel_d = ack_data_nx;
            end else if (go_receive_enable) begin
               st_d = ST_RX;
               scl_rel_d = 1'b0;
               sda_rel_d = 1'b1;
            end else if (go_tx) begin
               st_d = ST_TX;
               scl_rel_d = 1'b0;
               sr_d = wdata_i;
               sda_rel_d = wdata_i[7];
            end
         end
         ST_START: begin
            if (ph_q == PH0) begin
               if (!sda_s_q) begin
                  sda_rel_d = 1'b0;
                  ph_d = PH1;
               end else if (!scl_s_q) begin
                  bcl_ev = 1'b1;
               end else if (brg_tick) begin
                  sda_rel_d = 1'b0;
                  ph_d = PH1;
               end
            end else if (brg_tick) begin
               scl_rel_d = 1'b0;
               st_d = ST_IDLE;
               fin = 1'b1;
            end
         end
         ST_TX: begin
            if (ph_q == PH0) begin
               if (brg_tick) begin
                  scl_rel_d = 1'b1;
                  ph_d = PH1;
               end
            end else if (lost_one && cnt_q != CNT_ACK) begin
               bcl_ev = 1'b1;
               tx_bf_clr = 1'b1;
            end else if (brg_tick) begin
               scl_rel_d = 1'b0;
               ph_d = PH0;
               cnt_d = cnt_q + 4'h1;
               sr_d = {sr_q[6:0], 1'b0};
               sda_rel_d = sr_q[6];
               if (cnt_q == CNT_LAST) begin
                  sda_rel_d = 1'b1;
                  tx_bf_clr = 1'b1;
               end else if (cnt_q == CNT_ACK) begin
                  tx_ack = 1'b1;
                  fin = 1'b1;
                  st_d = ST_IDLE;
               end
            end
         end
         ST_RX: begin
            if (ph_q == PH0) begin
               if (brg_tick) begin
                  scl_rel_d = 1'b1;
                  ph_d = PH1;
               end
            end else if (brg_tick) begin
               scl_rel_d = 1'b0;
               ph_d = PH0;
               cnt_d = cnt_q + 4'h1;
               sr_d = {sr_q[6:0], sda_s_q};
               if (cnt_q == CNT_LAST) begin
                  rx_done = 1'b1;
                  st_d = ST_IDLE;
               end
            end
         end
         ST_ACK: begin
            if (ph_q == PH0) begin
               if (brg_tick) begin
                  scl_rel_d = 1'b1;
                  ph_d = PH1;
               end
            end else if (lost_one) begin
               bcl_ev = 1'b1;
            end else if (brg_tick) begin
               scl_rel_d = 1'b0;
               st_d = ST_IDLE;
            end
         end
         ST_STOP: begin
            if (brg_tick) begin
               if (ph_q == PH0) begin
                  scl_rel_d = 1'b1;
                  ph_d = PH1;
               end else if (ph_q == PH1) begin
                  sda_rel_d = 1'b1;
                  ph_d = PH2;
               end else begin
                  st_d = ST_IDLE;
                  fin = 1'b1;
               end
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
      if (bcl_ev || !en_q) begin
         st_d = ST_IDLE;
         scl_rel_d = 1'b1;
         sda_rel_d = 1'b1;
      end
   end

   // ==========================================
   // read mux
   wire [7:0] con1_v = {write_collision_q, ov_q, en_q, ie_q, 2'b00, bcl_q, flag_q};
   wire [7:0] con2_v = {1'b0, ackstat_q, ack_data_q, st_q == ST_ACK, st_q == ST_RX,
                        st_q == ST_STOP, 1'b0, st_q == ST_START};
   wire [7:0] stat_v = {3'b000, stopd_q, startd_q, 2'b00, bf_q};
   wire [7:0] rd_val = (addr_i == OFF_CON1) ? con1_v
                     : (addr_i == OFF_CON2) ? con2_v
                     : (addr_i == OFF_STAT) ? stat_v
                     : (addr_i == OFF_BUF) ? buf_q
                     : (addr_i == OFF_ADD) ? {1'b0, add_q}
                     : RST_BYTE;

   // ==========================================
   // pin sampling
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_m_q <= scl_i;
         scl_s_q <= scl_m_q;
         scl_p_q <= scl_s_q;
         sda_m_q <= sda_i;
         sda_s_q <= sda_m_q;
         sda_p_q <= sda_s_q;
      end
   end

   // ==========================================
   // sequencer registers
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_q <= ST_IDLE;
         ph_q <= PH0;
         cnt_q <= 4'h0;
         sr_q <= RST_BYTE;
         scl_rel_q <= 1'b1;
         sda_rel_q <= 1'b1;
      end else begin
         st_q <= st_d;
         ph_q <= ph_d;
         cnt_q <= cnt_d;
         sr_q <= sr_d;
         scl_rel_q <= scl_rel_d;
         sda_rel_q <= sda_rel_d;
      end
   end

   // ==========================================
   // software registers and flags, hardware set wins
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         en_q <= 1'b0;
         ie_q <= 1'b0;
         write_collision_q <= 1'b0;
         ov_q <= 1'b0;
         bcl_q <= 1'b0;
         flag_q <= 1'b0;
         bf_q <= 1'b0;
         buf_q <= RST_BYTE;
         add_q <= RST_RELOAD;
         ack_data_q <= 1'b0;
         ackstat_q <= 1'b0;
      end else begin
         if (wr_con1) begin
            en_q <= wdata_i[B_EN];
            ie_q <= wdata_i[B_IE];
         end
         write_collision_q <= upd(write_collision_q, wr_con1 && !wdata_i[B_WRITE_COLLISION], write_collision_ev);
         ov_q <= upd(ov_q, wr_con1 && !wdata_i[B_OV], rx_done && bf_q);
         bcl_q <= upd(bcl_q, wr_con1 && !wdata_i[B_BCL], bcl_ev);
         flag_q <= upd(flag_q, wr_con1 && !wdata_i[B_FLAG],
                       fin || rx_done || (stop_det && startd_q));
         bf_q <= upd(bf_q, rd_buf || tx_bf_clr || !en_q, rx_done || go_tx);
         if (rx_done) begin
            buf_q <= sr_d;
         end else if (go_tx) begin
            buf_q <= wdata_i;
         end
         if (wr_add) begin
            add_q <= wdata_i[6:0];
         end
         if (wr_con2) begin
            ack_data_q <= wdata_i[B_ACK_DATA];
         end
         if (tx_ack) begin
            ackstat_q <= sda_s_q;
         end
      end
   end

   // ==========================================
   // bus watch, outputs
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stopd_q <= 1'b0;
         startd_q <= 1'b0;
         wake_q <= 1'b0;
         rdata_q <= RST_BYTE;
         pin_q <= 1'b0;
      end else begin
         stopd_q <= en_q && upd(stopd_q, start_det, stop_det);
         startd_q <= en_q && upd(startd_q, stop_det, start_det);
         wake_q <= flag_q && ie_q;
         rdata_q <= rd_i ? rd_val : RST_BYTE;
         pin_q <= 1'b0;
      end
   end

   assign rdata_o = rdata_q;
   assign scl_o = pin_q;
   assign sda_o = pin_q;
   assign scl_oe_n_o = scl_rel_q;
   assign sda_oe_n_o = sda_rel_q;
   assign wake_o = wake_q;
endmodule // i2cm_core

//--- verif/i2cm_core_sva.sv
// checker: pin and read-port relations of the i2c master core
// assumes it is bound into i2cm_core and sees only its ports
`timescale 1ns/1ps
module i2cm_core_sva (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [i2cm_pkg::ADDR_W-1:0] addr_i,
   input wire logic [i2cm_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [i2cm_pkg::DATA_W-1:0] rdata_o,
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe_n_o,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n_o,
   input wire logic wake_o
);
   import i2cm_pkg::*;
   // ==========
   // properties
   default clocking dc @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   property p_open_drain; scl_o == 1'b0 && sda_o == 1'b0; endproperty
   a_open_drain: assert property (p_open_drain) else $error("pin data not low");
   property p_stretch; (scl_oe_n_o && !scl_i) [*4] |=> scl_oe_n_o; endproperty
   a_stretch: assert property (p_stretch) else $error("clock pulled while stretched");
   property p_rst_rel; $rose(nrst_i) |-> scl_oe_n_o && sda_oe_n_o && !wake_o; endproperty
   a_rst_rel: assert property (p_rst_rel) else $error("lines not released at reset");
   property p_start_low;
      wr_i && addr_i == OFF_CON2 && wdata_i[B_SEN] && scl_oe_n_o && sda_oe_n_o && !scl_i
         && !sda_i ##1 (!scl_i && !sda_i) [*6] |-> scl_oe_n_o && sda_oe_n_o;
   endproperty
   a_start_low: assert property (p_start_low) else $error("start drove busy lines");
   property p_start_end; $fell(sda_oe_n_o) && scl_oe_n_o |-> ##[1:130] (!scl_oe_n_o || sda_oe_n_o); endproperty
   a_start_end: assert property (p_start_end) else $error("start never lowered clock");
   property p_wake_off; wr_i && addr_i == OFF_CON1 && !wdata_i[B_IE] |-> ##2 !wake_o; endproperty
   a_wake_off: assert property (p_wake_off) else $error("wake with interrupt off");
   property p_rd_idle; !$past(rd_i) || $past(addr_i) > OFF_ADD |-> rdata_o == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
   property p_stat_rsv; $past(rd_i) && $past(addr_i) == OFF_STAT |-> rdata_o[7:5] == 3'h0 && rdata_o[2:1] == 2'h0; endproperty
   a_stat_rsv: assert property (p_stat_rsv) else $error("status spare bits set");
endmodule // i2cm_core_sva

bind i2cm_core i2cm_core_sva i_i2cm_core_sva (.*);

//--- verif/i2cm_slave_model.sv
// slave-side model: sends a byte msb first, may stretch the clock
// assumes wired-and lines with pull-ups resolved by the bench
`timescale 1ns/1ps
module i2cm_slave_model (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic scl_i,
   input wire logic [7:0] byte_i,
   input wire logic load_i,
   input wire logic stretch_i,
   input wire logic hold_i,
   output logic scl_low_o,
   output logic sda_low_o
);
   logic scl_q;
   logic [7:0] sh_q;
   logic [3:0] cnt_q;
   logic [3:0] st_q;
   wire fall = scl_q && !scl_i;
   // ==========
   // shifter and stretch
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         scl_q <= 1'b1;
         sh_q <= 8'h00;
         cnt_q <= 4'h0;
         st_q <= 4'h0;
      end else begin
         scl_q <= scl_i;
         if (load_i) begin
            sh_q <= byte_i;
            cnt_q <= 4'h8;
         end else if (fall && cnt_q != 4'h0) begin
            sh_q <= {sh_q[6:0], 1'b1};
            cnt_q <= cnt_q - 4'h1;
         end
         if (fall && stretch_i) begin
            st_q <= 4'hA;
         end else if (st_q != 4'h0) begin
            st_q <= st_q - 4'h1;
         end
      end
   end
   // hold stands for another master owning the bus
   assign sda_low_o = hold_i || (cnt_q != 4'h0 && !sh_q[7]);
   assign scl_low_o = hold_i || st_q != 4'h0;
endmodule // i2cm_slave_model

//--- verif/i2cm_core_tb.sv
// testbench for i2cm_core: register tasks, slave model, scenarios
// assumes the slave model and the bound checker are compiled first
`timescale 1ns/1ps
module i2cm_core_tb;
   import i2cm_pkg::*;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [ADDR_W-1:0] addr_i = '0;
   logic [DATA_W-1:0] wdata_i = '0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [DATA_W-1:0] rdata_o;
   logic scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, wake_o, scl_low, sda_low;
   logic load = 1'b0;
   logic stretch = 1'b0;
   logic hold = 1'b0;
   logic [7:0] sbyte = 8'h00;
   int n_errors = 0;
   int total_checks = 0;
   wire scl_w = (scl_oe_n_o | scl_o) & !scl_low;
   wire sda_w = (sda_oe_n_o | sda_o) & !sda_low;
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   i2cm_core i_i2cm_core (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl_w),
      .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_n_o(sda_oe_n_o), .wake_o(wake_o));
   i2cm_slave_model i_i2cm_slave_model (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_w),
      .byte_i(sbyte), .load_i(load), .stretch_i(stretch), .hold_i(hold),
      .scl_low_o(scl_low), .sda_low_o(sda_low));
   // ==========
   // tasks
   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task automatic rchk(input string what, input logic [2:0] a, input logic [7:0] m,
                       input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk(what, d & m, e);
   endtask
   task automatic poll(input logic [2:0] a, input int b, input logic v);
      logic [7:0] d;
      rd(a, d);
      for (int k = 0; k < 400 && d[b] !== v; k++) rd(a, d);
      if (d[b] !== v) begin
         n_errors++;
         $display("Error poll expected %b seen %b", v, d[b]);
         close_out();
      end
   endtask
   task automatic ld(input logic [7:0] b);
      sbyte <= b;
      load <= 1'b1;
      @(posedge clk_i);
      load <= 1'b0;
   endtask
   task automatic rx(input logic [7:0] b, input logic s);
      stretch <= s;
      ld(b);
      wr(OFF_CON2, 8'h08);
   endtask
   // ==========
   // scenarios
   initial begin
      logic [7:0] b0, b1;
      void'($urandom(99));
      repeat (4) @(posedge clk_i);
      nrst_i <= 1'b1;
      for (int a = 0; a < 8; a++) rchk("reset value", a[2:0], 8'hFF, 8'h00);
      $display("test reset done");
      wr(OFF_ADD, 8'h03);
      wr(OFF_CON1, 8'h30);
      rchk("bus free", OFF_STAT, 8'h18, 8'h00);
      wr(OFF_CON2, 8'h01);
      poll(OFF_CON2, B_SEN, 1'b0);
      chk("start pins", {6'h0, scl_oe_n_o, sda_oe_n_o}, 8'h00);
      rchk("start seen", OFF_STAT, 8'h08, 8'h08);
      $display("test start done");
      b0 = 8'($urandom);
      b1 = 8'($urandom);
      wr(OFF_CON1, 8'h30);
      rx(b0, 1'b0);
      wr(OFF_BUF, 8'hA5);
      poll(OFF_CON2, B_RECEIVE_ENABLE, 1'b0);
      chk("clock held", {7'h0, scl_oe_n_o}, 8'h00);
      chk("wake", {7'h0, wake_o}, 8'h01);
      rchk("full", OFF_STAT, 8'h01, 8'h01);
      rchk("write_collision rx", OFF_CON1, 8'h81, 8'h81);
      rx(b1, 1'b1);
      poll(OFF_CON2, B_RECEIVE_ENABLE, 1'b0);
      rchk("overflow", OFF_CON1, 8'h40, 8'h40);
      rchk("byte", OFF_BUF, 8'hFF, b1);
      rchk("full clear", OFF_STAT, 8'h01, 8'h00);
      wr(OFF_CON1, 8'h20);
      rchk("flags clear", OFF_CON1, 8'hC3, 8'h00);
      wr(OFF_CON1, 8'h30);
      $display("test receive done");
      for (int i = 0; i < 2; i++) begin
         wr(OFF_CON1, 8'h30);
         wr(OFF_CON2, {2'h0, i[0], 5'h10});
         wr(OFF_BUF, 8'h5A);
         chk("ack level", {7'h0, sda_oe_n_o}, {7'h0, i[0]});
         poll(OFF_CON2, B_ACK_SEQUENCE_ENABLE, 1'b0);
         chk("ack end", {7'h0, scl_oe_n_o}, 8'h00);
         rchk("write_collision ack", OFF_CON1, 8'h80, 8'h80);
         rchk("buffer kept", OFF_BUF, 8'hFF, b1);
      end
      $display("test ack done");
      wr(OFF_CON2, 8'h04);
      chk("stop data low", {7'h0, sda_oe_n_o}, 8'h00);
      poll(OFF_CON2, B_PEN, 1'b0);
      chk("stop lines", {6'h0, scl_oe_n_o, sda_oe_n_o}, 8'h03);
      rchk("stop seen", OFF_STAT, 8'h10, 8'h10);
      rchk("stop flag", OFF_CON1, 8'h01, 8'h01);
      $display("test stop done");
      wr(OFF_CON1, 8'h30);
      hold <= 1'b1;
      repeat (3) @(posedge clk_i);
      wr(OFF_CON2, 8'h01);
      poll(OFF_CON1, B_BCL, 1'b1);
      rchk("enables clear", OFF_CON2, 8'h1F, 8'h00);
      chk("released", {6'h0, scl_oe_n_o, sda_oe_n_o}, 8'h03);
      repeat (8) @(posedge clk_i);
      hold <= 1'b0;
      $display("test collision done");
      // slave holds data low, so a released one is lost
      ld(8'h00);
      repeat (4) @(posedge clk_i);
      wr(OFF_CON1, 8'h30);
      wr(OFF_BUF, 8'hFF);
      poll(OFF_CON1, B_BCL, 1'b1);
      rchk("tx full clear", OFF_STAT, 8'h01, 8'h00);
      chk("tx released", {6'h0, scl_oe_n_o, sda_oe_n_o}, 8'h03);
      wr(OFF_CON1, 8'h30);
      ld(8'hFF);
      repeat (4) @(posedge clk_i);
      rchk("bus stop flag", OFF_CON1, 8'h01, 8'h01);
      rchk("bus stop seen", OFF_STAT, 8'h10, 8'h10);
      wr(OFF_CON1, 8'h30);
      wr(OFF_BUF, 8'h7F);
      chk("first bit", {7'h0, sda_oe_n_o}, 8'h00);
      rchk("tx write taken", OFF_CON1, 8'h80, 8'h00);
      poll(OFF_CON1, B_FLAG, 1'b1);
      rchk("tx no collision", OFF_CON1, 8'h02, 8'h00);
      rchk("tx buffer", OFF_BUF, 8'hFF, 8'h7F);
      $display("test transmit done");
      @(posedge clk_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      rchk("reset clears", OFF_STAT, 8'hFF, 8'h00);
      $display("test second reset done");
      close_out();
   end
endmodule // i2cm_core_tb
